// >>> hdl/acr_bank.sv
// Control register bank for serial ports, converter and receiver policy
module acr_bank (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  // Register access from the control port (8-bit register frame)
  input  wire logic        i_write,
  input  wire logic        i_read,
  input  wire logic [7:0]  i_addr_frame,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata,
  output logic             o_rvalid,
  // Receiver state
  input  wire logic        i_pll_locked,
  input  wire logic        i_sample_valid,
  input  wire logic        i_frame_error,
  input  wire logic [23:0] i_rx_sample,
  input  wire logic [1:0]  i_rx_emphasis,
  // Candidate port clocks from other domains
  input  wire logic        i_pll_frame,
  input  wire logic        i_pll_bit,
  input  wire logic        i_internal_clock_one_frame,
  input  wire logic        i_internal_clock_one_bit,
  input  wire logic        i_internal_clock_two_frame,
  input  wire logic        i_internal_clock_two_bit,
  // Port clock pins
  output logic             o_aux_in_frame_clock,
  output logic             o_aux_in_bit_clock,
  output logic             o_aux_in_clock_oe,
  output logic             o_record_frame_clock,
  output logic             o_record_bit_clock,
  output logic             o_record_clock_oe,
  output logic             o_aux_out_frame_clock,
  output logic             o_aux_out_bit_clock,
  output logic             o_aux_out_clock_oe,
  // Decoded controls
  output logic [2:0]       o_aux_in_serial_format_select,
  output logic [4:0]       o_record_word_bits,
  output logic [1:0]       o_record_serial_format_select,
  output logic [4:0]       o_aux_out_word_bits,
  output logic [1:0]       o_aux_out_serial_format_select,
  output logic             o_converter_soft_mute,
  output logic [6:0]       o_converter_added_delay,
  output logic             o_rx_clock_from_internal_clock_one,
  output logic [9:0]       o_recovered_rate_ratio,
  output logic             o_deemphasis_active,
  // Receiver audio after error and lock policy
  output logic [23:0]      o_rx_sample,
  output logic             o_rx_soft_mute
);
  typedef struct packed {
    logic [7:0]  aux_in;
    logic [7:0]  record;
    logic [7:0]  aux_out;
    logic [7:0]  delay;
    logic [7:0]  rx_cfg1;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [23:0] last_good;
    logic [23:0] sample;
    logic        rx_mute;
    logic        deemph;
    logic [4:0]  rec_bits;
    logic [4:0]  aux_bits;
    logic [9:0]  ratio;
    logic        rx_internal_clock_one;
  } acr_bank_s;
  acr_bank_s state_reg, state_next;

  logic       locked_sync;
  logic       sync_pll_frame;
  logic       sync_pll_bit;
  logic       sync_i1_frame;
  logic       sync_i1_bit;
  logic       sync_i2_frame;
  logic       sync_i2_bit;
  logic [6:0] reg_addr;
  logic [2:0] err_pol;

  assign reg_addr = i_addr_frame[7:1]; // R15

  function automatic logic [4:0] word_bits(input logic [1:0] code); // R04
    unique case (code)
      2'h0: word_bits = acr_pkg::OUTPUT_WORD_LENGTH_24;
      2'h1: word_bits = acr_pkg::OUTPUT_WORD_LENGTH_20;
      2'h2: word_bits = acr_pkg::OUTPUT_WORD_LENGTH_18;
      2'h3: word_bits = acr_pkg::OUTPUT_WORD_LENGTH_16;
    endcase
  endfunction

  // Reserved format codes keep the stored value, so only legal codes land
  function automatic logic [7:0] out_port_write(input logic [7:0] old,
                                                input logic [7:0] wd);
    logic [7:0] v;
    v = wd & acr_pkg::MASK_OUT; // R17
    if (v[1:0] == acr_pkg::FMT_RESERVED) begin // R05 R07
      v[1:0] = old[1:0];
    end
    out_port_write = v;
  endfunction

  // Synchronisers for every level from another domain
  // Candidate clocks must stay well below i_clock or edges are lost
  acr_sync u_lock (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_pll_locked),
    .o_sync   (locked_sync)
  );

  acr_sync u_pf (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_pll_frame),
    .o_sync   (sync_pll_frame)
  );

  acr_sync u_pb (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_pll_bit),
    .o_sync   (sync_pll_bit)
  );

  acr_sync u_1f (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_internal_clock_one_frame),
    .o_sync   (sync_i1_frame)
  );

  acr_sync u_1b (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_internal_clock_one_bit),
    .o_sync   (sync_i1_bit)
  );

  acr_sync u_2f (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_internal_clock_two_frame),
    .o_sync   (sync_i2_frame)
  );

  acr_sync u_2b (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  (i_internal_clock_two_bit),
    .o_sync   (sync_i2_bit)
  );

  // Pins follow a source change one cycle late and a candidate
  // clock edge three cycles late (two sync flops, one output flop)
  acr_port_clock u_aux_in (
    .i_clock         (i_clock),
    .i_resetn        (i_resetn),
    .i_timing_source (state_reg.aux_in[acr_pkg::SRC_LSB_IN +: 2]), // R01
    .i_pll_frame     (sync_pll_frame),
    .i_pll_bit       (sync_pll_bit),
    .i_internal_clock_one_frame   (sync_i1_frame),
    .i_internal_clock_one_bit     (sync_i1_bit),
    .i_internal_clock_two_frame   (sync_i2_frame),
    .i_internal_clock_two_bit     (sync_i2_bit),
    .o_frame_clock   (o_aux_in_frame_clock),
    .o_bit_clock     (o_aux_in_bit_clock),
    .o_clock_oe      (o_aux_in_clock_oe)
  );

  acr_port_clock u_record (
    .i_clock         (i_clock),
    .i_resetn        (i_resetn),
    .i_timing_source (state_reg.record[acr_pkg::SRC_LSB_OUT +: 2]), // R03
    .i_pll_frame     (sync_pll_frame),
    .i_pll_bit       (sync_pll_bit),
    .i_internal_clock_one_frame   (sync_i1_frame),
    .i_internal_clock_one_bit     (sync_i1_bit),
    .i_internal_clock_two_frame   (sync_i2_frame),
    .i_internal_clock_two_bit     (sync_i2_bit),
    .o_frame_clock   (o_record_frame_clock),
    .o_bit_clock     (o_record_bit_clock),
    .o_clock_oe      (o_record_clock_oe)
  );

  acr_port_clock u_aux_out (
    .i_clock         (i_clock),
    .i_resetn        (i_resetn),
    .i_timing_source (state_reg.aux_out[acr_pkg::SRC_LSB_OUT +: 2]), // R06
    .i_pll_frame     (sync_pll_frame),
    .i_pll_bit       (sync_pll_bit),
    .i_internal_clock_one_frame   (sync_i1_frame),
    .i_internal_clock_one_bit     (sync_i1_bit),
    .i_internal_clock_two_frame   (sync_i2_frame),
    .i_internal_clock_two_bit     (sync_i2_bit),
    .o_frame_clock   (o_aux_out_frame_clock),
    .o_bit_clock     (o_aux_out_bit_clock),
    .o_clock_oe      (o_aux_out_clock_oe)
  );

  assign err_pol = {1'b0, state_reg.rx_cfg1[3:2]};

  always_comb begin
    state_next        = state_reg;
    state_next.rvalid = 1'b0;
    if (i_write) begin
      unique case (reg_addr)
        acr_pkg::ADDR_AUX_IN: begin
          state_next.aux_in = i_wdata & acr_pkg::MASK_AUX_IN; // R17 R02
        end
        acr_pkg::ADDR_RECORD: begin
          state_next.record = out_port_write(state_reg.record, i_wdata);
        end
        acr_pkg::ADDR_AUX_OUT: begin
          state_next.aux_out = out_port_write(state_reg.aux_out, i_wdata);
        end
        acr_pkg::ADDR_DELAY: begin
          state_next.delay = i_wdata & acr_pkg::MASK_FULL; // R08 R09
        end
        acr_pkg::ADDR_RX_CFG1: begin
          state_next.rx_cfg1 = i_wdata; // R10 R11 R12 R13 R14
        end
        default: begin
        end
      endcase
    end
    if (i_read) begin
      state_next.rvalid = 1'b1;
      // Unmapped addresses read as zero
      unique case (reg_addr)
        acr_pkg::ADDR_AUX_IN:  state_next.rdata = state_reg.aux_in;
        acr_pkg::ADDR_RECORD:  state_next.rdata = state_reg.record;
        acr_pkg::ADDR_AUX_OUT: state_next.rdata = state_reg.aux_out;
        acr_pkg::ADDR_DELAY:   state_next.rdata = state_reg.delay;
        acr_pkg::ADDR_RX_CFG1: state_next.rdata = state_reg.rx_cfg1;
        default:               state_next.rdata = 8'h00;
      endcase
    end
    state_next.rec_bits = word_bits(state_reg.record[3:2]); // R04
    state_next.aux_bits = word_bits(state_reg.aux_out[3:2]); // R04
    // Reserved ratio code reports zero rather than guess a rate
    unique case (state_reg.rx_cfg1[6:5])
      2'h0: state_next.ratio = acr_pkg::RATIO_128; // R11
      2'h1: state_next.ratio = acr_pkg::RATIO_256; // R11
      2'h2: state_next.ratio = acr_pkg::RATIO_512; // R11
      2'h3: state_next.ratio = 10'h000;
    endcase
    state_next.deemph = state_reg.rx_cfg1[4] &&
                        (i_rx_emphasis != 2'h0); // R12
    // Fallback select only matters while the receiver PLL is unlocked
    state_next.rx_internal_clock_one = !locked_sync &&
                          state_reg.rx_cfg1[7]; // R10
    // Sample path: lock loss takes priority over a single bad frame
    if (i_sample_valid) begin
      state_next.rx_mute = 1'b0;
      if (!locked_sync) begin
        unique case (state_reg.rx_cfg1[1:0]) // R14
          acr_pkg::POL_NONE: state_next.sample = i_rx_sample;
          acr_pkg::POL_HOLD: state_next.sample = state_reg.last_good;
          acr_pkg::POL_ZERO: state_next.sample = 24'h000000;
          acr_pkg::POL_MUTE: begin
            state_next.sample  = state_reg.last_good;
            state_next.rx_mute = 1'b1;
          end
        endcase
      end else if (i_frame_error) begin
        // Reserved policy 11 behaves as no action
        unique case (err_pol[1:0]) // R13
          acr_pkg::POL_HOLD: state_next.sample = state_reg.last_good;
          acr_pkg::POL_ZERO: state_next.sample = 24'h000000;
          default:           state_next.sample = i_rx_sample;
        endcase
      end else begin
        // Only a clean locked sample may become the held value
        state_next.sample    = i_rx_sample;
        state_next.last_good = i_rx_sample;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg          <= '0;
      state_reg.ratio    <= acr_pkg::RATIO_128;
      state_reg.rec_bits <= acr_pkg::OUTPUT_WORD_LENGTH_24;
      state_reg.aux_bits <= acr_pkg::OUTPUT_WORD_LENGTH_24;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata                        = state_reg.rdata;
  assign o_rvalid                       = state_reg.rvalid;
  assign o_aux_in_serial_format_select  = state_reg.aux_in[2:0]; // R02
  assign o_record_word_bits             = state_reg.rec_bits;
  assign o_record_serial_format_select  = state_reg.record[1:0]; // R05
  assign o_aux_out_word_bits            = state_reg.aux_bits;
  assign o_aux_out_serial_format_select = state_reg.aux_out[1:0]; // R07
  assign o_converter_soft_mute          = state_reg.delay[7]; // R08
  assign o_converter_added_delay        = state_reg.delay[6:0]; // R09
  assign o_rx_clock_from_internal_clock_one          = state_reg.rx_internal_clock_one; // R10
  assign o_recovered_rate_ratio         = state_reg.ratio;
  assign o_deemphasis_active            = state_reg.deemph;
  assign o_rx_sample                    = state_reg.sample;
  assign o_rx_soft_mute                 = state_reg.rx_mute;
endmodule

// >>> common/acr_pkg.sv
// Constants for the audio port, converter and receiver control bank
// Behaviour
// [R01] Aux input timing source: 00 slave, 01 recovered PLL, 10 internal one, 11 internal two.
// [R02] Aux input format: 000 LJ, 001 I2S, 100/101/110/111 right-justified 24/20/18/16.
// [R03] Record port timing source: 00 slave, else clocks from PLL, internal one or two.
// [R04] Record and aux output word length: 00 24, 01 20, 10 18, 11 16 bits.
// [R05] Record port format: 00 LJ, 01 I2S, 11 RJ; 10 is reserved.
// [R06] Aux output timing source: 00 slave, else PLL, internal one or two.
// [R07] Aux output format: 00 LJ, 01 I2S, 11 RJ; 10 is reserved.
// [R08] Converter mute bit 7 soft-mutes the converter output when set.
// [R09] Seven-bit added delay delays the converter filter by 0 to 127 input samples.
// [R10] While unlocked, receiver clock is PLL clock on 0 and internal clock one on 1.
// [R11] Recovered rate field gives 128, 256, 512 times fs for 00, 01, 10; 11 reserved.
// [R12] Automatic de-emphasis bit applies de-emphasis per channel status when set.
// [R13] On parity or biphase error: 00 nothing, 01 hold last, 10 zeros; 11 reserved.
// [R14] On lock loss: 00 nothing, 01 hold last, 10 zeros after it, 11 soft-mute.
// [R15] The host sends the 7-bit register address left-shifted into an 8-bit frame.
// [R16] A slave port's frame and bit clocks come from outside; the device does not drive them.
// [R17] Reserved bits read as zero and writes to them have no effect.
package acr_pkg;
  localparam logic [6:0] ADDR_AUX_IN  = 7'h05;
  localparam logic [6:0] ADDR_RECORD  = 7'h06;
  localparam logic [6:0] ADDR_AUX_OUT = 7'h07;
  localparam logic [6:0] ADDR_DELAY   = 7'h08;
  localparam logic [6:0] ADDR_RX_CFG1 = 7'h09;
  localparam logic [7:0] MASK_AUX_IN  = 8'h1F;
  localparam logic [7:0] MASK_OUT     = 8'h3F;
  localparam logic [7:0] MASK_FULL    = 8'hFF;
  localparam logic [7:0] RESET_VALUE  = 8'h00;
  localparam logic [6:0] DEVICE_BASE  = 7'h20;
  localparam int         SRC_LSB_OUT  = 4;
  localparam int         SRC_LSB_IN   = 3;
  localparam logic [1:0] SRC_SLAVE    = 2'h0;
  localparam logic [1:0] SRC_PLL      = 2'h1;
  localparam logic [1:0] SRC_INTERNAL_CLOCK_ONE    = 2'h2;
  localparam logic [1:0] SRC_INTERNAL_CLOCK_TWO    = 2'h3;
  localparam logic [1:0] FMT_RESERVED = 2'h2;
  localparam logic [1:0] POL_NONE     = 2'h0;
  localparam logic [1:0] POL_HOLD     = 2'h1;
  localparam logic [1:0] POL_ZERO     = 2'h2;
  localparam logic [1:0] POL_MUTE     = 2'h3;
  localparam logic [4:0] OUTPUT_WORD_LENGTH_24      = 5'h18;
  localparam logic [4:0] OUTPUT_WORD_LENGTH_20      = 5'h14;
  localparam logic [4:0] OUTPUT_WORD_LENGTH_18      = 5'h12;
  localparam logic [4:0] OUTPUT_WORD_LENGTH_16      = 5'h10;
  localparam logic [9:0] RATIO_128    = 10'h080;
  localparam logic [9:0] RATIO_256    = 10'h100;
  localparam logic [9:0] RATIO_512    = 10'h200;
  localparam int         SYNC_STAGES  = 2;
endpackage

// >>> hdl/acr_sync.sv
// Two-stage synchroniser for a level from outside the clock domain
module acr_sync (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_resetn,
  // Level
  input  wire logic i_async,
  output logic      o_sync
);
  typedef struct packed {
    logic meta;
    logic sync;
  } acr_sync_s;
  acr_sync_s state_reg, state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.meta = i_async;
    state_next.sync = state_reg.meta;
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_sync = state_reg.sync;
endmodule

// >>> hdl/acr_port_clock.sv
// Clock source selection for one serial port's frame and bit clocks
module acr_port_clock (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_resetn,
  // Selection
  input  wire logic [1:0] i_timing_source,
  // Candidate clocks, already synchronised
  input  wire logic       i_pll_frame,
  input  wire logic       i_pll_bit,
  input  wire logic       i_internal_clock_one_frame,
  input  wire logic       i_internal_clock_one_bit,
  input  wire logic       i_internal_clock_two_frame,
  input  wire logic       i_internal_clock_two_bit,
  // Pins
  output logic            o_frame_clock,
  output logic            o_bit_clock,
  output logic            o_clock_oe
);
  typedef struct packed {
    logic frame;
    logic bitc;
    logic oe;
  } acr_pclk_s;
  acr_pclk_s state_reg, state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.oe = (i_timing_source != acr_pkg::SRC_SLAVE); // R16
    unique case (i_timing_source)
      acr_pkg::SRC_SLAVE: begin
        state_next.frame = 1'b0;
        state_next.bitc  = 1'b0;
      end
      acr_pkg::SRC_PLL: begin
        state_next.frame = i_pll_frame;
        state_next.bitc  = i_pll_bit;
      end
      acr_pkg::SRC_INTERNAL_CLOCK_ONE: begin
        state_next.frame = i_internal_clock_one_frame;
        state_next.bitc  = i_internal_clock_one_bit;
      end
      acr_pkg::SRC_INTERNAL_CLOCK_TWO: begin
        state_next.frame = i_internal_clock_two_frame;
        state_next.bitc  = i_internal_clock_two_bit;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_frame_clock = state_reg.frame;
  assign o_bit_clock   = state_reg.bitc;
  assign o_clock_oe    = state_reg.oe;
endmodule

// >>> sim/acr_bank_monitor.sv
// Port assertions for the control bank
module acr_bank_monitor (
  // Clock and reset
  input wire logic        i_clock,
  input wire logic        i_resetn,
  // Watched inputs
  input wire logic        i_read,
  input wire logic        i_sample_valid,
  input wire logic [1:0]  i_rx_emphasis,
  input wire logic        i_pll_locked,
  // Watched outputs
  input wire logic        o_rvalid,
  input wire logic        o_aux_in_frame_clock,
  input wire logic        o_aux_in_bit_clock,
  input wire logic        o_aux_in_clock_oe,
  input wire logic        o_record_frame_clock,
  input wire logic        o_record_bit_clock,
  input wire logic        o_record_clock_oe,
  input wire logic        o_aux_out_frame_clock,
  input wire logic        o_aux_out_bit_clock,
  input wire logic        o_aux_out_clock_oe,
  input wire logic [4:0]  o_record_word_bits,
  input wire logic [9:0]  o_recovered_rate_ratio,
  input wire logic        o_rx_clock_from_internal_clock_one,
  input wire logic        o_deemphasis_active,
  input wire logic [23:0] o_rx_sample
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_resetn);
  AST_RD_ACK: assert property (i_read |=> o_rvalid)
    else $error("read not answered");
  AST_RD_ONE: assert property (!i_read |=> !o_rvalid)
    else $error("stray read answer");
  AST_AIN_SLAVE: assert property (!o_aux_in_clock_oe |->
    !o_aux_in_frame_clock && !o_aux_in_bit_clock)
    else $error("aux in clocks driven while slave");
  AST_REC_SLAVE: assert property (!o_record_clock_oe |->
    !o_record_frame_clock && !o_record_bit_clock)
    else $error("record clocks driven while slave");
  AST_AOUT_SLAVE: assert property (!o_aux_out_clock_oe |->
    !o_aux_out_frame_clock && !o_aux_out_bit_clock)
    else $error("aux out clocks driven while slave");
  AST_REC_OUTPUT_WORD_LENGTH: assert property (o_record_word_bits inside
    {5'h18, 5'h14, 5'h12, 5'h10})
    else $error("record word length off table");
  AST_RATIO: assert property (o_recovered_rate_ratio inside
    {10'h000, 10'h080, 10'h100, 10'h200})
    else $error("rate ratio off table");
  AST_DEEMPH: assert property (o_deemphasis_active |->
    $past(i_rx_emphasis) != 2'h0)
    else $error("de-emphasis without emphasis");
  AST_HOLD: assert property (!i_sample_valid |=> $stable(o_rx_sample))
    else $error("sample changed without strobe");
  AST_FALLBACK: assert property (o_rx_clock_from_internal_clock_one |->
    !$past(i_pll_locked, 3))
    else $error("fallback clock selected while locked");
endmodule

bind acr_bank acr_bank_monitor u_mon (.*);

// >>> sim/acr_host_model.sv
// Host side of the register port
module acr_host_model (
  // Clock
  input  wire logic       i_clock,
  // Answer
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  // Requests
  output logic            o_write,
  output logic            o_read,
  output logic [7:0]      o_addr_frame,
  output logic [7:0]      o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_write      = 1'b0;
    o_read       = 1'b0;
    o_addr_frame = 8'h00;
    o_wdata      = 8'h00;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clock);
    o_write      <= 1'b1;
    o_addr_frame <= {a, 1'b0};
    o_wdata      <= d;
    @(posedge i_clock);
    o_write      <= 1'b0;
    // Stale data must not look valid
    o_wdata      <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge i_clock);
    o_read       <= 1'b1;
    o_addr_frame <= {a, 1'b0};
    @(posedge i_clock);
    o_read       <= 1'b0;
    #1;
    ok = i_rvalid;
    d  = i_rdata;
  endtask
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for the control bank
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, wr_en, rd_en, rvalid, locked, svalid, ferr;
  logic [7:0]  addr, wdata, rdata;
  logic [23:0] sample, rx_out;
  logic [1:0]  emph, rec_fmt, aout_fmt;
  logic [5:0]  cand;
  logic [2:0]  ain_fmt;
  logic [4:0]  rec_wl, aout_wl;
  logic [8:0]  pins;
  logic        smute, from_ic1, deemph, rx_mute;
  logic [6:0]  gdly;
  logic [9:0]  ratio;
  int          num_errors, num_checks;
  logic [2:0]  fmts [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [4:0]  wl [4] = '{5'h18, 5'h14, 5'h12, 5'h10};
  logic [9:0]  rates [4] = '{10'h080, 10'h100, 10'h200, 10'h000};
  logic [23:0] ep [3] = '{24'hABCDEF, 24'h123456, 24'h000000};
  logic [23:0] lp [4] = '{24'h0F0F0F, 24'h654321, 24'h000000, 24'h654321};

  acr_host_model host (.i_clock(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_write(wr_en), .o_read(rd_en), .o_addr_frame(addr), .o_wdata(wdata));

  acr_bank uut (.i_clock(clk), .i_resetn(rstn), .i_write(wr_en),
    .i_read(rd_en), .i_addr_frame(addr), .i_wdata(wdata), .o_rdata(rdata),
    .o_rvalid(rvalid), .i_pll_locked(locked), .i_sample_valid(svalid),
    .i_frame_error(ferr), .i_rx_sample(sample), .i_rx_emphasis(emph),
    .i_pll_frame(cand[0]), .i_pll_bit(cand[1]), .i_internal_clock_one_frame(cand[2]),
    .i_internal_clock_one_bit(cand[3]), .i_internal_clock_two_frame(cand[4]), .i_internal_clock_two_bit(cand[5]),
    .o_aux_in_frame_clock(pins[0]), .o_aux_in_bit_clock(pins[1]),
    .o_aux_in_clock_oe(pins[2]), .o_record_frame_clock(pins[3]),
    .o_record_bit_clock(pins[4]), .o_record_clock_oe(pins[5]),
    .o_aux_out_frame_clock(pins[6]), .o_aux_out_bit_clock(pins[7]),
    .o_aux_out_clock_oe(pins[8]), .o_aux_in_serial_format_select(ain_fmt),
    .o_record_word_bits(rec_wl), .o_record_serial_format_select(rec_fmt),
    .o_aux_out_word_bits(aout_wl), .o_aux_out_serial_format_select(aout_fmt),
    .o_converter_soft_mute(smute), .o_converter_added_delay(gdly),
    .o_rx_clock_from_internal_clock_one(from_ic1), .o_recovered_rate_ratio(ratio),
    .o_deemphasis_active(deemph), .o_rx_sample(rx_out),
    .o_rx_soft_mute(rx_mute));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string n, input logic [23:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.rd(a, d, ok);
    chk("rvalid", {23'h0, ok}, 24'h1);
    chk("rdata", {16'h0, d}, {16'h0, e});
  endtask

  // Decoded fields lag the write by two cycles
  task automatic wset(input logic [6:0] a, input logic [7:0] d);
    host.wr(a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [23:0] s, input logic e);
    @(posedge clk);
    svalid <= 1'b1;
    sample <= s;
    ferr   <= e;
    @(posedge clk);
    svalid <= 1'b0;
    #1;
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    rstn = 1'b0;
    svalid = 1'b0;
    ferr = 1'b0;
    sample = 24'h000000;
    emph = 2'h0;
    locked = 1'b1;
    // Each source gets its own frame and bit level pair
    cand = 6'h39;
    num_errors = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 5; a < 11; a++) rchk(7'(a), 8'h00);
    for (int a = 5; a < 11; a++) host.wr(7'(a), 8'hFF);
    rchk(7'h05, 8'h1F);
    rchk(7'h06, 8'h3F);
    rchk(7'h07, 8'h3F);
    rchk(7'h08, 8'hFF);
    rchk(7'h0A, 8'h00);
    #1;
    chk("delay", 24'(gdly), 24'h00007F);
    chk("smute", 24'(smute), 24'h1);
    chk("fallback", 24'(from_ic1), 24'h0);
    wset(7'h08, 8'h00);
    chk("smute", 24'(smute), 24'h0);
    for (int s = 0; s < 4; s++) begin
      wset(7'h05, 8'(s << 3));
      wset(7'h06, 8'(s * 20 + 1));
      wset(7'h07, 8'(s * 20 + 3));
      chk("pins", 24'(pins), 24'({3{s != 0, 2'(s)}}));
      chk("rec_wl", 24'(rec_wl), 24'(wl[s]));
      chk("aout_wl", 24'(aout_wl), 24'(wl[s]));
      chk("fmts", 24'({rec_fmt, aout_fmt}), 24'h7);
    end
    wset(7'h06, 8'h02);
    wset(7'h07, 8'h02);
    rchk(7'h06, 8'h01);
    rchk(7'h07, 8'h03);
    foreach (fmts[i]) begin
      wset(7'h05, {5'h00, fmts[i]});
      chk("ain_fmt", 24'(ain_fmt), 24'(fmts[i]));
    end
    for (int r = 0; r < 4; r++) begin
      wset(7'h09, 8'(r << 5 | 16));
      chk("ratio", 24'(ratio), 24'(rates[r]));
    end
    chk("deemph", 24'(deemph), 24'h0);
    @(posedge clk);
    emph <= 2'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("deemph", 24'(deemph), 24'h1);
    for (int p = 0; p < 3; p++) begin
      wset(7'h09, 8'(p << 2));
      send(24'h123456, 1'b0);
      send(24'hABCDEF, 1'b1);
      chk("err", rx_out, ep[p]);
    end
    send(24'h654321, 1'b0);
    @(posedge clk);
    locked <= 1'b0;
    repeat (4) @(posedge clk);
    for (int p = 1; p < 5; p++) begin
      wset(7'h09, 8'(p % 4));
      send(24'h0F0F0F, 1'b0);
      chk("lock", rx_out, lp[p % 4]);
      chk("rx_mute", 24'(rx_mute), 24'(p == 3));
    end
    wset(7'h09, 8'h80);
    chk("fallback", 24'(from_ic1), 24'h1);
    print_verdict();
  end
endmodule
